// ### burner_ignition_safety_sequencer.sv
// burner ignition and safety sequencer with an ahb-lite register slave
// assumes panel and comparator inputs synchronous to hclk; word access only
`timescale 1ns/1ps
`include "burner_seq_cfg.svh"
module burner_ignition_safety_sequencer
  import burner_seq_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SEC = `CLK_HZ
)(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // operator panel
  input  wire logic                 start_button,
  input  wire logic                 safety_override_switch,
  input  wire logic [`LEVEL_W-1:0]  extinction_level,
  // burner hardware
  input  wire logic [`LEVEL_W-1:0]  tc_level,
  output logic                      heater_ignite,
  output logic                      heater_preheat,
  output logic                      gas_solenoid_valve,
  output logic                      flame_ok_relay,
  output logic                      alarm_out,
  // lamps
  output logic                      ignite_lamp,
  output logic                      running_lamp,
  output logic                      alarm_lamp,
  // interrupt
  output logic                      irq
);
  // bus state
  logic              wr_pend_ff;
  logic [11:0]       wr_addr_ff;
  logic [31:0]       rdata_ff;
  // registers
  logic              low_cal_ff;
  logic [4:0]        heater_on_time_ff;
  logic [4:0]        heater_off_time_ff;
  logic [`EVT_W-1:0] irq_stat_ff;
  logic [`EVT_W-1:0] irq_mask_ff;
  // sequencer
  seq_state_t        state_ff;
  seq_state_t        nxt_state;
  logic [2:0]        attempt_ff;
  logic [2:0]        nxt_attempt;
  logic              start_d_ff;
  // output flops
  logic              heat_ign_ff;
  logic              heat_pre_ff;
  logic              valve_ff;
  logic              relay_ff;
  logic              alarm_ff;
  logic              lamp_ign_ff;
  logic              lamp_run_ff;
  logic              lamp_alm_ff;
  logic              irq_ff;
  logic              tmr_load;
  logic [4:0]        tmr_secs;
  logic [`EVT_W-1:0] evt;

  wire               tmr_done;
  wire               above_ext;
  wire               overheat;

  // address phase decode
  wire        addr_ok   = hsel && hready && htrans[1];
  wire        rd_req    = addr_ok && !hwrite;
  wire        wr_req    = addr_ok && hwrite;
  wire [11:0] ofs       = haddr[11:0];
  wire        hi_zero   = (haddr[31:12] == 20'h0);
  wire        rd_status = rd_req && hi_zero && (ofs == `OFS_IRQ_STAT);

  wire wr_ctrl = wr_pend_ff && (wr_addr_ff == `OFS_CTRL);
  wire wr_ton  = wr_pend_ff && (wr_addr_ff == `OFS_TON);
  wire wr_toff = wr_pend_ff && (wr_addr_ff == `OFS_TOFF);
  wire wr_mask = wr_pend_ff && (wr_addr_ff == `OFS_IRQ_MASK);

  // clamp written times into the legal window
  wire [4:0] wsec      = (hwdata[31:5] != 27'h0) ? `MAX_SECS : hwdata[4:0];
  wire [4:0] clamp_sec = (wsec < `MIN_SECS) ? `MIN_SECS :
                         (wsec > `MAX_SECS) ? `MAX_SECS : wsec; // RQ4

  wire [31:0] status_word = {22'h0, overheat, above_ext, 1'b0,
                             attempt_ff, 1'b0, state_ff};
  wire [31:0] rd_mux =
    !hi_zero                   ? 32'h0 :
    (ofs == `OFS_CTRL)         ? {31'h0, low_cal_ff} :
    (ofs == `OFS_TON)          ? {27'h0, heater_on_time_ff} :
    (ofs == `OFS_TOFF)         ? {27'h0, heater_off_time_ff} :
    (ofs == `OFS_STATUS)       ? status_word :
    (ofs == `OFS_IRQ_STAT)     ? {28'h0, irq_stat_ff} :
    (ofs == `OFS_IRQ_MASK)     ? {28'h0, irq_mask_ff} : 32'h0;

  // panel decode
  wire start_push = start_button && !start_d_ff;
  wire released   = safety_override_switch;
  wire can_start  = start_push && !released;                     // RQ14
  wire last_try   = (attempt_ff == `MAX_ATTEMPTS);

  // bus slave
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h0;
      rdata_ff   <= 32'h0;
    end
    else
    begin
      wr_pend_ff <= wr_req && hi_zero;
      wr_addr_ff <= ofs;
      rdata_ff   <= rd_req ? rd_mux : 32'h0;
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      low_cal_ff         <= 1'b0;
      heater_on_time_ff  <= `TON_RESET;
      heater_off_time_ff <= `TOFF_RESET;
      irq_mask_ff        <= '0;
    end
    else
    begin
      if (wr_ctrl)
        low_cal_ff <= hwdata[`CTRL_LOW_CAL];
      if (wr_ton)
        heater_on_time_ff <= clamp_sec;                           // RQ4
      if (wr_toff)
        heater_off_time_ff <= clamp_sec;                          // RQ4
      if (wr_mask)
        irq_mask_ff <= hwdata[`EVT_W-1:0];
    end
  end

  // sticky events, read clears, a new event wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_ff <= '0;
    else
      irq_stat_ff <= (rd_status ? '0 : irq_stat_ff) | evt;
  end

  // sequence next state
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_attempt = attempt_ff;
    tmr_load    = 1'b0;
    tmr_secs    = heater_on_time_ff;
    evt         = '0;
    case (state_ff)
      ST_ALARM:
      begin
        if (released)
          nxt_state = ST_RELEASE;                                 // RQ15
        else if (can_start)                                       // RQ1 RQ7 RQ12
        begin
          nxt_state   = ST_IGN_ON;
          nxt_attempt = 3'h1;
          tmr_load    = 1'b1;                                     // RQ17
        end
      end
      ST_IGN_ON, ST_IGN_OFF:
      begin
        if (released)
          nxt_state = ST_RELEASE;
        else if (overheat)
        begin
          nxt_state = ST_ALARM;                                   // RQ10
          evt[`EVT_OVERHEAT] = 1'b1;
        end
        else if (above_ext)
        begin
          nxt_state = ST_RUN;                                     // RQ5
          evt[`EVT_LIT] = 1'b1;
        end
        else if (tmr_done && state_ff == ST_IGN_ON)
        begin
          if (last_try)
          begin
            nxt_state = ST_ALARM;                                 // RQ6
            evt[`EVT_FAIL] = 1'b1;
          end
          else
          begin
            nxt_state = ST_IGN_OFF;                               // RQ2
            tmr_load  = 1'b1;
            tmr_secs  = heater_off_time_ff;
          end
        end
        else if (tmr_done)
        begin
          nxt_state   = ST_IGN_ON;                                // RQ2
          nxt_attempt = attempt_ff + 3'h1;
          tmr_load    = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (released)
          nxt_state = ST_RELEASE;
        else if (overheat)
        begin
          nxt_state = ST_ALARM;                                   // RQ10
          evt[`EVT_OVERHEAT] = 1'b1;
        end
        else if (!above_ext)
        begin
          nxt_state = ST_ALARM;                                   // RQ8
          evt[`EVT_EXTINCT] = 1'b1;
        end
      end
      ST_RELEASE:
      begin
        if (!released)
          nxt_state = above_ext ? ST_RUN : ST_ALARM;
      end
      default:
        nxt_state = ST_ALARM;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff   <= ST_ALARM;                                     // RQ17
      attempt_ff <= 3'h0;
      start_d_ff <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      attempt_ff <= nxt_attempt;
      start_d_ff <= start_button;
    end
  end

  // outputs follow the new state
  wire n_ign  = (nxt_state == ST_IGN_ON);
  wire n_seq  = n_ign || (nxt_state == ST_IGN_OFF);
  wire n_run  = (nxt_state == ST_RUN);
  wire n_alm  = (nxt_state == ST_ALARM);
  wire n_rel  = (nxt_state == ST_RELEASE);
  wire n_irq  = |(((rd_status ? '0 : irq_stat_ff) | evt) & irq_mask_ff);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      heat_ign_ff <= 1'b0;
      heat_pre_ff <= 1'b0;
      valve_ff    <= 1'b0;                                        // RQ17
      relay_ff    <= 1'b0;
      alarm_ff    <= 1'b1;
      lamp_ign_ff <= 1'b0;
      lamp_run_ff <= 1'b0;
      lamp_alm_ff <= 1'b1;
      irq_ff      <= 1'b0;
    end
    else
    begin
      heat_ign_ff <= n_ign && !low_cal_ff;                        // RQ3
      heat_pre_ff <= n_ign && low_cal_ff;                         // RQ3
      valve_ff    <= n_seq || n_run || n_rel;                     // RQ9 RQ15
      relay_ff    <= n_run;                                       // RQ8
      alarm_ff    <= n_alm;                                       // RQ9 RQ15
      lamp_ign_ff <= n_seq;                                       // RQ13 RQ16
      lamp_run_ff <= n_run;                                       // RQ16
      lamp_alm_ff <= n_alm;                                       // RQ16
      irq_ff      <= n_irq;
    end
  end

  sec_interval_timer #(
    .CYCLES_PER_SEC (CYCLES_PER_SEC)
  ) u_timer (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .load      (tmr_load),
    .load_secs (tmr_secs),
    .done      (tmr_done)
  );

  flame_level_monitor u_level (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .tc_level         (tc_level),
    .extinction_level (extinction_level),
    .above_ext        (above_ext),
    .overheat         (overheat)
  );

  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = rdata_ff;
  assign heater_ignite      = heat_ign_ff;
  assign heater_preheat     = heat_pre_ff;
  assign gas_solenoid_valve = valve_ff;
  assign flame_ok_relay     = relay_ff;
  assign alarm_out          = alarm_ff;
  assign ignite_lamp        = lamp_ign_ff;
  assign running_lamp       = lamp_run_ff;
  assign alarm_lamp         = lamp_alm_ff;
  assign irq                = irq_ff;
endmodule

// ### burner_ignition_safety_sequencer_bench.sv
// self-checking bench of the burner sequencer with a plant model
// assumes the cfg header register map and ten cycles per second
`timescale 1ns/1ps
`include "burner_seq_cfg.svh"
module burner_ignition_safety_sequencer_bench;
  localparam int CPS = 10;
  logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp, rdy_q;
  logic [31:0]         haddr, hwdata, hrdata, rd_q, v, r;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic                start_button, safety_override_switch, heater_ignite;
  logic                heater_preheat, gas_solenoid_valve, flame_ok_relay, alarm_out;
  logic                ignite_lamp, running_lamp, alarm_lamp, irq, ignitable, hot, prev;
  logic [`LEVEL_W-1:0] extinction_level, tc_level;
  int                  miscompares, check_count, seed, i, n, hc, gap;
  logic [31:0]         cn [4] = '{32'h1, 32'h2, 32'h14, 32'h15};
  wire                 hready = hreadyout;
  wire  [4:0]          obs = {heater_ignite | heater_preheat, irq, alarm_lamp,
                              running_lamp, ignite_lamp};

  burner_ignition_safety_sequencer #(.CYCLES_PER_SEC(CPS))
    burner_ignition_safety_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .start_button(start_button),
    .safety_override_switch(safety_override_switch), .extinction_level(extinction_level),
    .tc_level(tc_level), .heater_ignite(heater_ignite), .heater_preheat(heater_preheat),
    .gas_solenoid_valve(gas_solenoid_valve), .flame_ok_relay(flame_ok_relay),
    .alarm_out(alarm_out), .ignite_lamp(ignite_lamp), .running_lamp(running_lamp),
    .alarm_lamp(alarm_lamp), .irq(irq));
  burner_plant_model burner_plant_model_i (
    .hclk(hclk), .gas_solenoid_valve(gas_solenoid_valve), .heater_ignite(heater_ignite),
    .heater_preheat(heater_preheat), .ignitable(ignitable), .hot(hot), .tc_level(tc_level));

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    rd_q  <= hrdata;
    rdy_q <= hreadyout;
  end

  function automatic logic [31:0] clp(input logic [31:0] x);
    return (x < 2) ? 32'h2 : (x > 20) ? 32'h14 : x;
  endfunction
  task tk;
    @(posedge hclk);
    #1;
  endtask
  task results;
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task hold;
    n = 0;
    do
    begin
      tk;
      n++;
    end
    while (rdy_q !== 1'b1 && n < 50);
    if (rdy_q !== 1'b1)
    begin
      miscompares++;
      results;
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hold;
    htrans <= 2'h0;
    hwdata <= d;
    hold;
    r = rd_q;
  endtask
  task wt(input int b, input logic x);
    n = 0;
    while (obs[b] !== x && n < 600)
    begin
      tk;
      n++;
    end
    if (obs[b] !== x)
    begin
      miscompares++;
      $display("BAD wait%0d expected %b seen %b", b, x, obs[b]);
      results;
    end
  endtask
  task push;
    start_button <= 1'b1;
    repeat (2) tk;
    start_button <= 1'b0;
    tk;
  endtask

  initial
  begin
    seed = 32'h8c3d707b;
    miscompares = 0;
    check_count = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    start_button = 1'b0;
    safety_override_switch = 1'b0;
    extinction_level = 12'h200;
    ignitable = 1'b0;
    hot = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    tk;
    chk("rst_out", {alarm_out, alarm_lamp, gas_solenoid_valve, ignite_lamp}, 4'hc);
    bus(0, `OFS_TON, 0);
    chk("ton_rst", r, 32'h5);
    chk("bus_resp", {hreadyout, hresp}, 2'h2);
    for (i = 0; i < 12; i++)
    begin
      v = (i < 4) ? cn[i] : {$random(seed)} % 41;
      bus(1, i[0] ? `OFS_TOFF : `OFS_TON, v);
      bus(0, i[0] ? `OFS_TOFF : `OFS_TON, 0);
      chk("time_reg", r, clp(v));
    end
    bus(1, 32'h20, 32'hffffffff);
    bus(0, 32'h20, 0);
    chk("unmapped", r, 0);
    bus(1, `OFS_TON, 2);
    bus(1, `OFS_TOFF, 3);
    bus(1, `OFS_IRQ_MASK, 0);
    bus(0, `OFS_IRQ_STAT, 0);
    extinction_level <= 12'h100 + 12'({$random(seed)} % 1024);
    start_button <= 1'b1;
    hc = 0;
    n = 0;
    gap = 0;
    prev = 1'b0;
    for (i = 0; i < 2000 && !(alarm_lamp === 1'b1 && i > 4); i++)
    begin
      tk;
      if (i == 2)
        start_button <= 1'b0;
      if (obs[4] && !prev)
        n++;
      if (obs[4])
        hc++;
      gap = obs[4] ? 0 : gap + 1;
      prev = obs[4];
    end
    chk("attempts", n, 5);
    chk("on_time", hc >= 10 * CPS && hc <= 10 * CPS + 15, 1);
    chk("cycle_len", i >= 22 * CPS && i <= 22 * CPS + 30, 1);
    chk("stop_gap", gap <= 3, 1);
    wt(2, 1);
    chk("irq_masked", irq, 0);
    bus(1, `OFS_IRQ_MASK, 32'hf);
    wt(3, 1);
    bus(0, `OFS_IRQ_STAT, 0);
    chk("stat_fail", r, 32'h1 << `EVT_FAIL);
    bus(0, `OFS_STATUS, 0);
    chk("status", r, 32'h50);
    wt(3, 0);
    safety_override_switch <= 1'b1;
    tk;
    push;
    repeat (4) tk;
    chk("release", {obs[4], ignite_lamp, gas_solenoid_valve, alarm_out}, 4'h2);
    safety_override_switch <= 1'b0;
    wt(2, 1);
    bus(1, `OFS_CTRL, 1);
    bus(0, `OFS_IRQ_STAT, 0);
    ignitable <= 1'b1;
    push;
    wt(4, 1);
    chk("preheat", {heater_ignite, heater_preheat}, 2'h1);
    wt(1, 1);
    chk("lit", {flame_ok_relay, ignite_lamp, gas_solenoid_valve}, 3'h5);
    bus(0, `OFS_IRQ_STAT, 0);
    chk("stat_lit", r, 32'h1 << `EVT_LIT);
    extinction_level <= 12'h900;
    wt(2, 1);
    chk("extinct", {gas_solenoid_valve, alarm_out, flame_ok_relay}, 3'h2);
    wt(3, 1);
    bus(0, `OFS_IRQ_STAT, 0);
    chk("stat_ext", r, 32'h1 << `EVT_EXTINCT);
    bus(1, `OFS_CTRL, 0);
    extinction_level <= 12'h100 + 12'({$random(seed)} % 1024);
    push;
    wt(4, 1);
    chk("ignite", {heater_ignite, heater_preheat}, 2'h2);
    wt(1, 1);
    hot <= 1'b1;
    wt(2, 1);
    chk("overheat", {gas_solenoid_valve, alarm_out}, 2'h1);
    bus(0, `OFS_IRQ_STAT, 0);
    chk("stat_hot", r, (32'h1 << `EVT_LIT) | (32'h1 << `EVT_OVERHEAT));
    results;
  end
endmodule

bind burner_ignition_safety_sequencer burner_seq_asserts burner_seq_asserts_i (
  .hclk(hclk), .hresetn(hresetn), .start_button(start_button),
  .safety_override_switch(safety_override_switch), .extinction_level(extinction_level),
  .tc_level(tc_level), .heater_ignite(heater_ignite), .heater_preheat(heater_preheat),
  .gas_solenoid_valve(gas_solenoid_valve), .flame_ok_relay(flame_ok_relay),
  .alarm_out(alarm_out), .ignite_lamp(ignite_lamp), .running_lamp(running_lamp),
  .alarm_lamp(alarm_lamp));

// ### burner_plant_model.sv
// heater, gas line and flame with the amplified thermocouple level
// assumes the bench sets ignitable and hot as burner conditions
`timescale 1ns/1ps
`include "burner_seq_cfg.svh"
module burner_plant_model (
  // clock
  input wire logic                 hclk,
  // from the sequencer
  input wire logic                 gas_solenoid_valve,
  input wire logic                 heater_ignite,
  input wire logic                 heater_preheat,
  // burner conditions
  input wire logic                 ignitable,
  input wire logic                 hot,
  // level
  output logic [`LEVEL_W-1:0]      tc_level
);
  logic       lit_ff = 1'b0;
  logic [3:0] warm_ff = 4'h0;
  wire        heat = heater_ignite | heater_preheat;
  // flame needs gas and nine cycles of heater drive
  wire        nxt_lit = gas_solenoid_valve & ignitable & (lit_ff | (heat & warm_ff[3]));
  wire  [3:0] nxt_warm = !heat ? 4'h0 : warm_ff[3] ? warm_ff : warm_ff + 4'h1;
  always_ff @(posedge hclk)
  begin
    lit_ff  <= nxt_lit;
    warm_ff <= nxt_warm;
  end
  assign tc_level = !lit_ff ? 12'h010 : hot ? 12'he80 : 12'h900;
endmodule

// ### burner_seq_asserts.sv
// concurrent checks on the sequencer panel and burner ports
// assumes it is bound to the sequencer top module
`timescale 1ns/1ps
`include "burner_seq_cfg.svh"
module burner_seq_asserts (
  // clock and reset
  input wire logic                hclk,
  input wire logic                hresetn,
  // panel
  input wire logic                start_button,
  input wire logic                safety_override_switch,
  input wire logic [`LEVEL_W-1:0] extinction_level,
  // burner
  input wire logic [`LEVEL_W-1:0] tc_level,
  input wire logic                heater_ignite,
  input wire logic                heater_preheat,
  input wire logic                gas_solenoid_valve,
  input wire logic                flame_ok_relay,
  input wire logic                alarm_out,
  // lamps
  input wire logic                ignite_lamp,
  input wire logic                running_lamp,
  input wire logic                alarm_lamp
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire heat = heater_ignite | heater_preheat;
  wire ovr  = safety_override_switch;

  property p_shut;
    alarm_lamp |-> !gas_solenoid_valve && alarm_out && !flame_ok_relay;
  endproperty
  a_shut: assert property (p_shut) else $error("alarm lamp without shutdown");
  property p_start;
    $rose(start_button) && alarm_lamp && !ovr |-> ##[1:3] ignite_lamp;
  endproperty
  a_start: assert property (p_start) else $error("start push ignored");
  property p_drive;
    heat |-> ignite_lamp && !(heater_ignite && heater_preheat);
  endproperty
  a_drive: assert property (p_drive) else $error("heater drive outside ignition");
  property p_lit;
    ignite_lamp && !ovr && tc_level > extinction_level && tc_level <= `OVERHEAT_LEVEL
      |-> ##[1:3] running_lamp;
  endproperty
  a_lit: assert property (p_lit) else $error("flame not taken as lit");
  property p_ext;
    running_lamp && !ovr && tc_level <= extinction_level |-> ##[1:3] !flame_ok_relay;
  endproperty
  a_ext: assert property (p_ext) else $error("relay kept on extinction");
  property p_hot;
    (ignite_lamp || running_lamp) && !ovr && tc_level > `OVERHEAT_LEVEL |-> ##[1:3] alarm_out;
  endproperty
  a_hot: assert property (p_hot) else $error("overheat not alarmed");
  property p_run;
    running_lamp |-> flame_ok_relay && gas_solenoid_valve && !alarm_out && !ignite_lamp;
  endproperty
  a_run: assert property (p_run) else $error("running outputs wrong");
  property p_ign;
    ignite_lamp |-> gas_solenoid_valve && !alarm_lamp && !running_lamp && !alarm_out;
  endproperty
  a_ign: assert property (p_ign) else $error("ignition lamps wrong");
  property p_noign;
    ovr [*4] |-> !heat && !ignite_lamp;
  endproperty
  a_noign: assert property (p_noign) else $error("ignition under override");
  property p_rel;
    ovr [*4] |-> gas_solenoid_valve && !alarm_out && !alarm_lamp;
  endproperty
  a_rel: assert property (p_rel) else $error("override not releasing");
endmodule

// ### burner_seq_cfg.svh
// constants of the burner ignition and safety sequencer
// assumes a 40 MHz hclk and a 12-bit digitised thermocouple level
// Notes on behaviour
// RQ1: a start push begins ignition unless something blocks it
// RQ2: heater-on then heater-off per cycle, at most five cycles per start
// RQ3: low-calorie mode drives preheat instead of ignition during heater-on
// RQ4: heater-on and heater-off times set separately, 2 to 20 seconds
// RQ5: level above extinction threshold ends ignition, burner counted as lit
// RQ6: no flame by end of fifth heater-on: stop right there
// RQ7: after failure stay idle until start is pushed again
// RQ8: while measuring, level below extinction drops the flame-ok relay
// RQ9: relay drop closes gas valve and raises alarm at once
// RQ10: level above 120 percent of span is overheat, same shutdown
// RQ11: extinction threshold comes from an operator-set level input
// RQ12: after alarm shutdown a new start push restarts ignition
// RQ13: indicator lamps follow the sequence state
// RQ14: override in release ignores start and never ignites
// RQ15: override in release opens valve, clears alarm, no extinction alarm
// RQ16: ignition lamp on while igniting, running lamp on success, else alarm; in release the code lights no lamp
// RQ17: intervals timed by clock counters; reset lands in alarm, valve shut
`ifndef BURNER_SEQ_CFG_SVH
`define BURNER_SEQ_CFG_SVH

`define CLK_HZ          40000000
`define MAX_ATTEMPTS    3'h5
`define MIN_SECS        5'h02
`define MAX_SECS        5'h14
`define TON_RESET       5'h05
`define TOFF_RESET      5'h05
`define LEVEL_W         12
`define SPAN_LEVEL      12'hbb8
`define OVERHEAT_PCT    120
`define OVERHEAT_LEVEL  12'(`SPAN_LEVEL * `OVERHEAT_PCT / 100)

`define OFS_CTRL        12'h000
`define OFS_TON         12'h004
`define OFS_TOFF        12'h008
`define OFS_STATUS      12'h00c
`define OFS_IRQ_STAT    12'h010
`define OFS_IRQ_MASK    12'h014

`define CTRL_LOW_CAL    0
`define EVT_LIT         0
`define EVT_FAIL        1
`define EVT_EXTINCT     2
`define EVT_OVERHEAT    3
`define EVT_W           4

`endif

// ### burner_seq_pkg.sv
// types shared by the burner sequencer modules
// assumes nothing beyond the cfg header
package burner_seq_pkg;
  typedef enum logic [2:0] {
    ST_ALARM   = 3'b000,
    ST_IGN_ON  = 3'b001,
    ST_IGN_OFF = 3'b010,
    ST_RUN     = 3'b011,
    ST_RELEASE = 3'b100
  } seq_state_t;
endpackage

// ### flame_level_monitor.sv
// registered threshold compare of the amplified thermocouple level
// assumes tc_level and extinction_level are synchronous to hclk
`timescale 1ns/1ps
`include "burner_seq_cfg.svh"
module flame_level_monitor
  import burner_seq_pkg::*;
(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // levels
  input  wire logic [`LEVEL_W-1:0]  tc_level,
  input  wire logic [`LEVEL_W-1:0]  extinction_level,
  // flags
  output logic                      above_ext,
  output logic                      overheat
);
  logic above_ff;
  logic hot_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      above_ff <= 1'b0;
      hot_ff   <= 1'b0;
    end
    else
    begin
      above_ff <= tc_level > extinction_level;   // RQ11
      hot_ff   <= tc_level > `OVERHEAT_LEVEL;     // RQ10
    end
  end

  assign above_ext = above_ff;
  assign overheat  = hot_ff;
endmodule

// ### sec_interval_timer.sv
// seconds down-counter with a one-cycle done pulse
// assumes load is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
`include "burner_seq_cfg.svh"
module sec_interval_timer
  import burner_seq_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SEC = `CLK_HZ
)(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       load,
  input  wire logic [4:0] load_secs,
  output logic            done
);
  logic [25:0] pre_ff;
  logic [4:0]  secs_ff;
  logic        run_ff;
  logic        done_ff;
  wire         tick = (pre_ff == 26'(CYCLES_PER_SEC - 1));
  wire         last = tick && (secs_ff == 5'h01);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_ff  <= 26'h0;
      secs_ff <= 5'h0;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (load)
    begin
      pre_ff  <= 26'h0;
      secs_ff <= load_secs;
      run_ff  <= 1'b1;
      done_ff <= 1'b0;
    end
    else
    begin
      pre_ff  <= (!run_ff || tick) ? 26'h0 : pre_ff + 26'h1; // RQ17
      secs_ff <= (run_ff && tick) ? secs_ff - 5'h1 : secs_ff;
      run_ff  <= run_ff && !last;
      done_ff <= run_ff && last;
    end
  end

  assign done = done_ff;
endmodule
